/* File: pbs_regs.vh */
// constants of the pipelined burst sram port
`ifndef PBS_REGS_VH
`define PBS_REGS_VH
`define PBS_ORDER_LINEAR     1'b0
`define PBS_BURST_CNT_W      2
`define PBS_BURST_CNT_RESET  2'h0
`define PBS_OE_RESET         1'b0
`define PBS_BUF_DEPTH        2
`endif

/* File: pbs_pair_buffer.v */
// small fifo with valid/ready on both sides, default two entries
`timescale 1ns/100ps
`default_nettype none
module pbs_pair_buffer #(
  parameter WIDTH = 36,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             reset_n,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0]   fill;
  wire            push;
  wire            pop;

  assign in_ready  = (fill != DEPTH[PTR_W:0]);
  assign out_valid = (fill != {(PTR_W+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // pointers wrap on the power-of-two depth
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      fill   <= {(PTR_W+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop)
        fill <= fill + 1'b1;
      else if (pop & ~push)
        fill <= fill - 1'b1;
    end
  end
endmodule // pbs_pair_buffer
`default_nettype wire

/* File: pbs_sram_port.v */
// synchronous pipelined burst sram access port with its array
`include "pbs_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_port #(
  parameter ADDR_W = 18,
  parameter DATA_W = 36,
  parameter BYTES  = 4
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              reset_n,
  // address and control from the controller
  input  wire [ADDR_W-1:0] address,
  input  wire              read_write_n,
  input  wire              advance_not_load,
  input  wire [BYTES-1:0]  byte_write_n,
  input  wire              chip_select_a_n,
  input  wire              chip_select_b,
  input  wire              chip_select_c_n,
  input  wire              clock_hold_n,
  input  wire              burst_order_select,
  // shared data bus, split into its three signals
  input  wire [DATA_W-1:0] data_in,
  output reg  [DATA_W-1:0] data_out,
  output reg               data_oe
);
  localparam BYTE_W = DATA_W / BYTES;
  localparam CW     = `PBS_BURST_CNT_W;

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // the array is not reset: contents are unknown until written
  // one command through the port, counting enabled edges only:
  //   edge 0  command sampled, burst counter loads or steps, read word fetched
  //   edge 1  command in stage one; a read word moves to the output
  //   edge 2  command in stage two; a write beat is taken from the bus
  // held edges move nothing, so both latencies stretch by the stall

  // burst state
  reg              burst_active;
  reg              burst_write;
  reg [ADDR_W-1:0] burst_base;
  reg [CW-1:0]     burst_count;
  // pipeline: stage one is one enabled edge after the command
  reg              s1_valid;
  reg              s1_write;
  reg [ADDR_W-1:0] s1_addr;
  reg [BYTES-1:0]  s1_bw_n;
  reg              s2_valid;
  reg              s2_write;
  reg [ADDR_W-1:0] s2_addr;
  reg [BYTES-1:0]  s2_bw_n;

  wire              enabled;
  wire              selected;
  wire              load;
  wire              advance;
  wire              cmd_valid;
  wire              cmd_write;
  wire [CW-1:0]     next_count;
  wire [CW-1:0]     burst_low;
  wire [ADDR_W-1:0] cmd_addr;
  wire              commit;
  wire              push_req;
  wire              buf_in_ready;
  wire              buf_out_valid;
  wire [DATA_W-1:0] buf_out_data;
  wire              go;
  wire [DATA_W-1:0] push_data;
  wire [DATA_W-1:0] pop_data;

  // clock hold high freezes every register of the port
  assign enabled  = ~clock_hold_n;
  // all three selects must agree; any one off turns a load into a stop
  assign selected = ~chip_select_a_n & ~chip_select_c_n
                    & chip_select_b;
  assign load     = ~advance_not_load & selected;
  // advance with no burst open (after a stop) is a no-op
  assign advance  = advance_not_load & burst_active;
  assign cmd_valid = load | advance;
  assign cmd_write = load ? ~read_write_n : burst_write;
  assign next_count = burst_count + 1'b1;
  assign burst_low  = (burst_order_select == `PBS_ORDER_LINEAR) ?
                      burst_base[CW-1:0] + next_count :
                      burst_base[CW-1:0] ^ next_count;
  assign cmd_addr = load ? address :
                    {burst_base[ADDR_W-1:CW], burst_low};

  // a full buffer stalls the whole port rather than drop a read word
  // only reads need the buffer; writes and deselects pass it by
  assign push_req = cmd_valid & ~cmd_write;
  assign go       = enabled & (buf_in_ready | ~push_req);
  assign commit   = go & s2_valid & s2_write;

  // merge the byte lanes of a write committing in this same edge
  function [DATA_W-1:0] merge;
    input [DATA_W-1:0] old_word;
    input [DATA_W-1:0] new_word;
    input [BYTES-1:0]  bw_n;
    input              hit;
    integer            i;
    // hit gates the whole merge; lanes with their enable high keep the
    // old word
    begin
      merge = old_word;
      for (i = 0; i < BYTES; i = i + 1) begin
        if (hit && !bw_n[i])
          merge[i*BYTE_W +: BYTE_W] = new_word[i*BYTE_W +: BYTE_W];
      end
    end
  endfunction

  // read forwarding covers writes loaded one and two commands earlier
  assign push_data = merge(mem[cmd_addr], data_in, s2_bw_n,
                           commit && (s2_addr == cmd_addr));
  assign pop_data  = merge(buf_out_data, data_in, s2_bw_n,
                           commit && (s2_addr == s1_addr));

  // the read word is fetched when the command is taken and parked here
  // for one enabled edge; a write committing in that edge to the same
  // address is merged on the way out, so read after write sees new data
  pbs_pair_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (`PBS_BUF_DEPTH),
    .PTR_W (1)
  ) u_read_buffer (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (go & push_req),
    .in_ready  (buf_in_ready),
    .in_data   (push_data),
    .out_valid (buf_out_valid),
    .out_ready (go & s1_valid & ~s1_write),
    .out_data  (buf_out_data)
  );

  // array write: byte lanes gated by the enables captured with the command
  // no reset on the array keeps it a plain memory
  always @(posedge clk_sys) begin : array_write
    integer b;
    for (b = 0; b < BYTES; b = b + 1) begin
      if (commit && !s2_bw_n[b])
        mem[s2_addr][b*BYTE_W +: BYTE_W] <=
          data_in[b*BYTE_W +: BYTE_W];
    end
  end

  // a load restarts the burst at its base; a stop closes it so that a
  // later advance does nothing; the pipeline stages shift on every
  // edge with go high, whatever the command was
  // burst counter and command pipeline; all hold while clock hold is high
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_base   <= {ADDR_W{1'b0}};
      burst_count  <= `PBS_BURST_CNT_RESET;
      s1_valid     <= 1'b0;
      s1_write     <= 1'b0;
      s1_addr      <= {ADDR_W{1'b0}};
      s1_bw_n      <= {BYTES{1'b1}};
      s2_valid     <= 1'b0;
      s2_write     <= 1'b0;
      s2_addr      <= {ADDR_W{1'b0}};
      s2_bw_n      <= {BYTES{1'b1}};
    end else if (go) begin
      if (load) begin
        burst_active <= 1'b1;
        burst_write  <= ~read_write_n;
        burst_base   <= address;
        burst_count  <= `PBS_BURST_CNT_RESET;
      end else if (advance) begin
        burst_count  <= next_count;
      end else if (!advance_not_load) begin
        burst_active <= 1'b0;
      end
      s1_valid <= cmd_valid;
      s1_write <= cmd_write;
      s1_addr  <= cmd_addr;
      s1_bw_n  <= byte_write_n;
      // the older command moves on even while deselecting
      s2_valid <= s1_valid;
      s2_write <= s1_write;
      s2_addr  <= s1_addr;
      s2_bw_n  <= s1_bw_n;
    end
  end

  // a deselect, stop, no-op or write in stage one floats the bus on the
  // next enabled edge; data_out keeps its last word while floating so a
  // held edge never shows a changed value
  // output stage: drives in the cycle two commands after the read load
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= {DATA_W{1'b0}};
      data_oe  <= `PBS_OE_RESET;
    end else if (go) begin
      data_oe <= s1_valid & ~s1_write;
      if (s1_valid && !s1_write && buf_out_valid)
        data_out <= pop_data;
    end
  end
endmodule // pbs_sram_port
`default_nettype wire

/* File: pbs_ctl_model.sv */
// controller model driving the synchronous sram bus
`timescale 1ns/100ps
`default_nettype none
module pbs_ctl_model (
  // clock
  input  wire logic        clk_sys,
  // command pins
  output var  logic [17:0] address,
  output var  logic        clock_hold_n,
  output var  logic        advance_not_load,
  output var  logic        read_write_n,
  output var  logic        chip_select_a_n,
  output var  logic        chip_select_b,
  output var  logic        chip_select_c_n,
  output var  logic [3:0]  byte_write_n,
  // write data onto the shared bus
  output var  logic [35:0] wr_data,
  output var  logic        wr_drive
);
  initial begin
    // all bytes on for every beat, so no beat of a burst is lost
    byte_write_n = 4'h0;
    address = 18'h0_0000;
    wr_data = 36'h0_0000_0000;
    {clock_hold_n, advance_not_load, read_write_n, chip_select_a_n,
      chip_select_b, chip_select_c_n, wr_drive} = 7'h0c;
  end
  // one command cycle; bit 0 of c puts write data on the bus
  task automatic step(input logic [6:0] c, input logic [17:0] a,
                      input logic [35:0] d);
    @(posedge clk_sys);
    #1;
    {clock_hold_n, advance_not_load, read_write_n, chip_select_a_n,
      chip_select_b, chip_select_c_n, wr_drive} = c;
    address = a;
    if (c[0])
      wr_data = d;
  endtask
endmodule // pbs_ctl_model
`default_nettype wire

/* File: pbs_sram_port_monitor.sv */
// pin-level assertions for the burst sram port
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_port_monitor #(parameter DATA_W = 36) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // command pins
  input wire logic              read_write_n,
  input wire logic              advance_not_load,
  input wire logic              chip_select_a_n,
  input wire logic              chip_select_b,
  input wire logic              chip_select_c_n,
  input wire logic              clock_hold_n,
  // device driver
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic sel = !chip_select_a_n && !chip_select_c_n && chip_select_b;
  wire logic ld  = !clock_hold_n && !advance_not_load;
  wire logic rd  = ld && sel && read_write_n;
  wire logic wr  = ld && sel && !read_write_n;
  wire logic ds  = ld && !sel;
  a_reset_float: assert property ($rose(reset_n) |-> !data_oe)
    else $error("bus driven right after reset");
  a_hold_oe: assert property (clock_hold_n |=> $stable(data_oe))
    else $error("enable moved on a held edge");
  a_hold_data: assert property (clock_hold_n |=> $stable(data_out))
    else $error("read data moved on a held edge");
  a_read_latency: assert property (rd ##1 !clock_hold_n |=> data_oe)
    else $error("read word not driven after two edges");
  a_read_pair: assert property (rd ##1 rd ##1 !clock_hold_n
    |-> data_oe ##1 data_oe) else $error("back to back reads broke");
  a_stall_latency: assert property (rd ##1 clock_hold_n[*2]
    ##1 !clock_hold_n |=> data_oe) else $error("held edges counted");
  a_desel_float: assert property (ds ##1 !clock_hold_n
    |=> !data_oe) else $error("bus driven after deselect");
  a_write_float: assert property (wr ##1 !clock_hold_n
    |=> !data_oe) else $error("bus driven for a write");
endmodule // pbs_sram_port_monitor
bind pbs_sram_port pbs_sram_port_monitor #(.DATA_W(DATA_W)) mon (.*);
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [6:0] RD = 7'h14, WR = 7'h04, AV = 7'h24;
  localparam logic [6:0] DS = 7'h0c, HD = 7'h44;
  logic             clk_sys = 1'b0;
  logic             reset_n = 1'b0;
  logic             burst_order_select = 1'b0;
  logic [17:0]      address;
  logic             clock_hold_n, advance_not_load, read_write_n;
  logic             chip_select_a_n, chip_select_b, chip_select_c_n;
  logic [3:0]       byte_write_n;
  logic [35:0]      wr_data, data_out;
  logic             wr_drive, data_oe;
  wire logic [35:0] data_in;
  int               n_fail = 0, tests_run = 0, cycles = 0;
  // a released bus shows the inverse of the last word, not a stale copy
  assign data_in = data_oe ? data_out
                 : wr_drive ? wr_data : ~wr_data;
  always #5 clk_sys = ~clk_sys;
  pbs_sram_port uut (.*);
  pbs_ctl_model ctl (.*);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 600) begin
      n_fail++;
      complete_run;
    end
  end
  function automatic logic [35:0] dv(input logic [7:0] i);
    dv = {28'h9a5_c3e7, i};
  endfunction
  // one command, then the bus as seen in that same cycle
  task automatic cyc(input logic [6:0] c, input logic [17:0] a,
      input logic [35:0] d, input logic oe, input logic [35:0] q);
    ctl.step(c, a, d);
    tests_run++;
    if (data_oe !== oe || (oe && data_out !== q)) begin
      n_fail++;
      $display("FAIL %0t got %h %h exp %h %h", $time, data_oe, data_out, oe, q);
    end
  endtask
  task automatic burst_write;
    cyc(DS, 0, 0, 0, 0);
    cyc(WR, 6, 0, 0, 0);
    cyc(AV, 0, 0, 0, 0);
    cyc(AV + 1, 0, dv(0), 0, 0);
    cyc(AV + 1, 0, dv(1), 0, 0);
    cyc(AV + 1, 0, dv(2), 0, 0);
    cyc(WR + 1, 8, dv(3), 0, 0);
    cyc(AV + 1, 0, dv(4), 0, 0);
    cyc(DS + 1, 0, dv(5), 0, 0);
    cyc(DS + 1, 0, dv(6), 0, 0);
  endtask
  task automatic burst_read;
    cyc(RD, 4, 0, 0, 0);
    cyc(AV, 0, 0, 0, 0);
    cyc(AV, 0, 0, 1, dv(2));
    cyc(AV, 0, 0, 1, dv(3));
    cyc(RD, 8, 0, 1, dv(4));
    cyc(RD, 9, 0, 1, dv(1));
    cyc(DS, 0, 0, 1, dv(5));
    cyc(DS, 0, 0, 1, dv(6));
    cyc(DS, 0, 0, 0, 0);
  endtask
  task automatic hold_cycles;
    cyc(WR, 3, 0, 0, 0);
    cyc(HD, 0, 0, 0, 0);
    cyc(DS, 0, 0, 0, 0);
    cyc(HD, 0, 0, 0, 0);
    cyc(DS + 1, 0, dv(7), 0, 0);
    cyc(RD, 3, 0, 0, 0);
    cyc(HD, 0, 0, 0, 0);
    cyc(RD, 9, 0, 0, 0);
    cyc(HD, 0, 0, 1, dv(7));
    cyc(HD, 0, 0, 1, dv(7));
    cyc(RD, 8, 0, 1, dv(7));
    cyc(DS, 0, 0, 1, dv(6));
    cyc(DS, 0, 0, 1, dv(5));
    cyc(DS, 0, 0, 0, 0);
  endtask
  task automatic select_off;
    logic [6:0] off [3] = '{7'h1c, 7'h10, 7'h16};
    for (int k = 0; k < 3; k++) begin
      cyc(RD, 6, 0, 0, 0);
      cyc(off[k], 7, 0, 0, 0);
      cyc(AV, 0, 0, 1, dv(4));
      cyc(DS, 0, 0, 0, 0);
      cyc(DS, 0, 0, 0, 0);
    end
  endtask
  // interleaved order from base 5 visits 5, 4, 7, 6
  task automatic order_swap;
    burst_order_select = 1'b1;
    cyc(RD, 5, 0, 0, 0);
    cyc(AV, 0, 0, 0, 0);
    cyc(AV, 0, 0, 1, dv(3));
    cyc(AV, 0, 0, 1, dv(2));
    cyc(DS, 0, 0, 1, dv(1));
    cyc(DS, 0, 0, 1, dv(4));
    cyc(DS, 0, 0, 0, 0);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    burst_write;
    burst_read;
    hold_cycles;
    select_off;
    order_swap;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
